// ==== hdl/alu_defines.svh ====
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH
`define DATA_W       8
`define INSN_W       14
`define FADDR_W      7
`define PC_W         11
`define NIB_HI       3
`define NIB_LO_W     4
`define PH_ONE       4'h1
`define PH_TWO       4'h2
`define PH_THREE     4'h4
`define PH_FOUR      4'h8
`define ZERO_BYTE    8'h00
`define ONE_BYTE     8'h01
`define ACC_RESET    8'h00
`define IMM_LSB      0
`define FADDR_LSB    0
`define DEST_BIT     7
`define INDIR_ADDR   7'h00
`define FSR_ADDR     7'h04
`define STATUS_ADDR  7'h03
`define PCL_ADDR     7'h02
`define FLAG_C       0
`define FLAG_DC      1
`define FLAG_Z       2
`define CYCLE_1      2'h1
`define CYCLE_2      2'h2
`endif

// ==== hdl/alu_pkg.sv ====
`include "alu_defines.svh"
package alu_pkg;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
    OP_XOR = 4'h4, OP_RLF = 4'h5, OP_RRF = 4'h6, OP_COMF = 4'h7,
    OP_INCF = 4'h8, OP_DECF = 4'h9, OP_SWAP = 4'hA, OP_MOVF = 4'hB,
    OP_MOVW = 4'hC, OP_CLR = 4'hD, OP_NOP = 4'hE, OP_BRANCH = 4'hF
  } alu_op_e;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1, PH_Q2 = 4'h2, PH_Q3 = 4'h4, PH_Q4 = 4'h8
  } phase_e;
  typedef struct packed {
    alu_op_e             op;
    logic                use_imm;
    logic                src_file;
    logic                dest_file;
    logic                upd_c;
    logic                upd_dc;
    logic                upd_z;
    logic [`INSN_W-1:0]  insn;
  } decode_s;
  typedef struct packed {
    logic                   wr;
    logic [`FADDR_W-1:0]    addr;
    logic [`DATA_W-1:0]     data;
  } file_wr_s;
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } flags_s;
endpackage

// ==== hdl/alu_core.sv ====
`timescale 1ns/10ps
`include "alu_defines.svh"
module alu_core
  import alu_pkg::*;
(
  // Operation
  input  wire alu_op_e          op_in,
  input  wire logic [7:0]       a_in,
  input  wire logic [7:0]       b_in,
  input  wire logic             carry_in,
  // Result
  output logic [7:0]            res_out,
  output logic                  c_out,
  output logic                  dc_out
);
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    sum    = 9'h000;
    nib    = 5'h00;
    res_out = `ZERO_BYTE;
    c_out  = carry_in;
    dc_out = 1'h0;
    case (op_in)
      // [RL2] Twos complement add
      OP_ADD: begin
        sum    = {1'h0, a_in} + {1'h0, b_in};
        nib    = {1'h0, a_in[3:0]} + {1'h0, b_in[3:0]};
        res_out = sum[7:0];
        c_out  = sum[8];
        // [RL14] Carry from bit 3
        dc_out = nib[`NIB_LO_W];
      end
      // [RL7] Borrow via inverted carry
      OP_SUB: begin
        sum    = {1'h0, b_in} + {1'h0, ~a_in} + 9'h001;
        nib    = {1'h0, b_in[3:0]} + {1'h0, ~a_in[3:0]} + 5'h01;
        res_out = sum[7:0];
        // [RL13] Set when no borrow
        c_out  = sum[8];
        dc_out = nib[`NIB_LO_W];
      end
      // [RL1] Logic and shift set
      OP_AND:  res_out = a_in & b_in;
      OP_IOR:  res_out = a_in | b_in;
      OP_XOR:  res_out = a_in ^ b_in;
      OP_RLF: begin
        res_out = {b_in[6:0], carry_in};
        c_out  = b_in[7];
      end
      OP_RRF: begin
        res_out = {carry_in, b_in[7:1]};
        c_out  = b_in[0];
      end
      OP_COMF: res_out = ~b_in;
      OP_INCF: res_out = b_in + `ONE_BYTE;
      OP_DECF: res_out = b_in - `ONE_BYTE;
      OP_SWAP: res_out = {b_in[3:0], b_in[7:4]};
      OP_MOVF: res_out = b_in;
      OP_MOVW: res_out = a_in;
      default: res_out = `ZERO_BYTE;
    endcase
  end
endmodule

// ==== hdl/alu_working_register_datapath.sv ====
`timescale 1ns/10ps
`include "alu_defines.svh"
// Behaviour
// [RL1] 8-bit add, subtract, shift, logic
// [RL2] Arithmetic in twos complement
// [RL3] Accumulator with file or immediate
// [RL4] Single operand from accumulator or file
// [RL5] Accumulator not in data memory
// [RL6] Update C, DC, Z selectively
// [RL7] Subtract flags report borrows
// [RL8] Special registers live in data memory
// [RL9] Direct and indirect file addressing
// [RL10] 14-bit instruction carries immediate
// [RL11] Non-branch one cycle, branch two
// [RL12] Four phases per instruction cycle
// [RL13] Carry set means no borrow
// [RL14] DC from bit 3, Z on zero
module alu_working_register_datapath
  import alu_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  // Decoded instruction
  input  wire logic                 insn_valid_in,
  input  wire decode_s              dec_in,
  // File register read data
  input  wire logic [`DATA_W-1:0]   file_rdata_in,
  input  wire logic [`DATA_W-1:0]   fsr_in,
  input  wire flags_s               status_in,
  // File register access
  output logic [`FADDR_W-1:0]       file_raddr_out,
  output file_wr_s                  file_wr_out,
  output file_wr_s                  status_wr_out,
  // Core status
  output logic [`DATA_W-1:0]        acc_out,
  output phase_e                    phase_out,
  output logic                      cycle_end_out,
  output logic                      insn_ready_out,
  output logic                      busy_out
);
  phase_e                 phase_r;
  logic [1:0]             cycles_left_r;
  logic [`DATA_W-1:0]     acc_r;
  decode_s                cur_r;
  logic                   cur_valid_r;
  logic [`DATA_W-1:0]     operand_r;
  file_wr_s               file_wr_r;
  file_wr_s               status_wr_r;
  logic [`FADDR_W-1:0]    dir_addr;
  logic [`FADDR_W-1:0]    eff_addr;
  logic [`DATA_W-1:0]     imm;
  logic [`DATA_W-1:0]     b_opnd;
  logic [`DATA_W-1:0]     res;
  logic                   c_new;
  logic                   dc_new;
  flags_s                 flags_nxt;
  logic                   execute;

  // [RL12] Four phase rotation
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase_r <= PH_Q1;
    end else begin
      case (phase_r)
        PH_Q1:   phase_r <= PH_Q2;
        PH_Q2:   phase_r <= PH_Q3;
        PH_Q3:   phase_r <= PH_Q4;
        default: phase_r <= PH_Q1;
      endcase
    end
  end

  // [RL10] Latch word at end of fetch
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cur_r       <= '0;
      cur_valid_r <= 1'h0;
    end else if (phase_r == PH_Q4 && insn_ready_out) begin
      cur_r       <= dec_in;
      cur_valid_r <= insn_valid_in;
    end
  end

  // [RL11] Branches hold pipeline a cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cycles_left_r <= 2'h0;
    end else if (phase_r == PH_Q4) begin
      if (insn_ready_out && insn_valid_in && dec_in.op == OP_BRANCH) begin
        cycles_left_r <= `CYCLE_2;
      end else if (cycles_left_r != 2'h0) begin
        cycles_left_r <= cycles_left_r - `CYCLE_1;
      end
    end
  end

  assign insn_ready_out = (cycles_left_r <= `CYCLE_1);
  assign busy_out       = ~insn_ready_out;
  assign phase_out      = phase_r;
  assign cycle_end_out  = (phase_r == PH_Q4);
  assign execute        = cur_valid_r && (phase_r == PH_Q3);

  // [RL9] Direct or indirect address
  assign dir_addr = cur_r.insn[`FADDR_LSB +: `FADDR_W];
  assign eff_addr = (dir_addr == `INDIR_ADDR) ? fsr_in[`FADDR_W-1:0]
                                              : dir_addr;
  assign file_raddr_out = eff_addr;
  assign imm = cur_r.insn[`IMM_LSB +: `DATA_W];

  // Operand captured in second phase
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      operand_r <= `ZERO_BYTE;
    end else if (cur_valid_r && phase_r == PH_Q2) begin
      operand_r <= file_rdata_in;
    end
  end

  // [RL3] File or immediate second source
  // [RL4] Single operand source select
  assign b_opnd = cur_r.use_imm ? imm :
                  cur_r.src_file ? operand_r : acc_r;

  alu_core u_alu (
    .op_in    (cur_r.op),
    .a_in     (acc_r),
    .b_in     (b_opnd),
    .carry_in (status_in.c),
    .res_out  (res),
    .c_out    (c_new),
    .dc_out   (dc_new)
  );

  // [RL6] Only affected flags change
  always_comb begin
    flags_nxt = status_in;
    if (cur_r.upd_c) begin
      flags_nxt.c = c_new;
    end
    if (cur_r.upd_dc) begin
      flags_nxt.dc = dc_new;
    end
    // [RL14] Zero on all-zero result
    if (cur_r.upd_z) begin
      flags_nxt.z = (res == `ZERO_BYTE);
    end
  end

  // [RL5] Accumulator held privately
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc_r <= `ACC_RESET;
    end else if (execute && !cur_r.dest_file &&
                 cur_r.op != OP_NOP && cur_r.op != OP_BRANCH &&
                 cur_r.op != OP_MOVW) begin
      acc_r <= res;
    end
  end

  // [RL8] Results written to data memory
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      file_wr_r <= '0;
    end else begin
      file_wr_r.wr <= execute && cur_r.dest_file &&
                      cur_r.op != OP_NOP && cur_r.op != OP_BRANCH;
      file_wr_r.addr <= eff_addr;
      file_wr_r.data <= res;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      status_wr_r <= '0;
    end else begin
      status_wr_r.wr   <= execute &&
                          (cur_r.upd_c || cur_r.upd_dc || cur_r.upd_z);
      status_wr_r.addr <= `STATUS_ADDR;
      status_wr_r.data <= {5'h00, flags_nxt.z, flags_nxt.dc, flags_nxt.c};
    end
  end

  assign file_wr_out   = file_wr_r;
  assign status_wr_out = status_wr_r;
  assign acc_out       = acc_r;
endmodule

// ==== bench/alu_datapath_monitor.sv ====
`timescale 1ns/10ps
`include "alu_defines.svh"
module alu_datapath_monitor
  import alu_pkg::*;
(
  // Watched ports
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       insn_valid_in,
  input wire decode_s    dec_in,
  input wire logic [7:0] fsr_in,
  input wire logic [6:0] file_raddr_out,
  input wire file_wr_s   file_wr_out,
  input wire file_wr_s   status_wr_out,
  input wire logic [7:0] acc_out,
  input wire phase_e     phase_out,
  input wire logic       cycle_end_out,
  input wire logic       insn_ready_out,
  input wire logic       busy_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic take = phase_out == PH_Q4 && insn_ready_out && insn_valid_in;
  phase_walk_a:
    assert property (phase_out == PH_Q1 |=> phase_out == PH_Q2 ##1
      phase_out == PH_Q3 ##1 phase_out == PH_Q4 ##1 phase_out == PH_Q1)
      else $error("phase order");
  cycle_end_a:
    assert property (cycle_end_out == (phase_out == PH_Q4)) else $error("q4");
  ready_busy_a:
    assert property (busy_out != insn_ready_out) else $error("busy");
  wr_pulse_a:
    assert property (file_wr_out.wr |-> phase_out == PH_Q4 ##1
      !file_wr_out.wr) else $error("write pulse");
  status_fmt_a:
    assert property (status_wr_out.wr |-> phase_out == PH_Q4 &&
      status_wr_out.addr == `STATUS_ADDR && status_wr_out.data[7:3] == 5'h00)
      else $error("status write");
  acc_edge_a:
    assert property (!$stable(acc_out) |-> phase_out == PH_Q4)
      else $error("acc timing");
  branch_hold_a:
    assert property (take && dec_in.op == OP_BRANCH |-> ##4 !(insn_ready_out
      || file_wr_out.wr || status_wr_out.wr)) else $error("branch");
  indir_addr_a:
    assert property (take && !dec_in.use_imm && dec_in.insn[6:0] == 7'h00
      |=> file_raddr_out == fsr_in[6:0]) else $error("indirect");
endmodule
bind alu_working_register_datapath alu_datapath_monitor i_mon (
  .mclk_in, .rst_n_in, .insn_valid_in, .dec_in, .fsr_in, .file_raddr_out,
  .file_wr_out, .status_wr_out, .acc_out, .phase_out, .cycle_end_out,
  .insn_ready_out, .busy_out);

// ==== bench/alu_file_model.sv ====
`timescale 1ns/10ps
`include "alu_defines.svh"
module alu_file_model
  import alu_pkg::*;
(
  // Datapath side
  input  wire logic       mclk_in,
  input  wire logic [6:0] raddr_in,
  input  wire file_wr_s   wr_in,
  input  wire file_wr_s   swr_in,
  // Read side
  output logic [7:0]      rdata_out,
  output logic [7:0]      fsr_out,
  output flags_s          status_out
);
  logic [7:0] mem_r [128];
  initial for (int i = 0; i < 128; i++) mem_r[i] = 8'(i * 3);
  always @(posedge mclk_in) begin
    if (wr_in.wr) mem_r[wr_in.addr] <= wr_in.data;
    if (swr_in.wr) mem_r[`STATUS_ADDR] <= swr_in.data;
  end
  assign rdata_out = mem_r[raddr_in];
  assign fsr_out = mem_r[`FSR_ADDR];
  assign status_out = mem_r[`STATUS_ADDR][2:0];
endmodule

// ==== bench/alu_working_register_datapath_tb_top.sv ====
`timescale 1ns/10ps
module alu_working_register_datapath_tb_top
  import alu_pkg::*;
;
  typedef struct packed {
    decode_s    d;
    logic [7:0] res;
    logic       sw;
    logic [7:0] sd;
  } row_s;
  logic       mclk_in;
  logic       rst_n_in;
  logic       insn_valid_in;
  decode_s    dec_in;
  logic [7:0] file_rdata_in;
  logic [7:0] fsr_in;
  flags_s     status_in;
  logic [6:0] file_raddr_out;
  file_wr_s   file_wr_out;
  file_wr_s   status_wr_out;
  logic [7:0] acc_out;
  phase_e     phase_out;
  logic       cycle_end_out;
  logic       insn_ready_out;
  logic       busy_out;
  logic [7:0] acc_exp;
  int         mismatches = 0;
  int         num_checks = 0;
  row_s       rows [9] = '{
    {OP_CLR, 6'h01, 14'h0000, 8'h00, 1'h1, 8'h05},
    {OP_IOR, 6'h21, 14'h003C, 8'h3C, 1'h1, 8'h01},
    {OP_ADD, 6'h27, 14'h00C8, 8'h04, 1'h1, 8'h03},
    {OP_SUB, 6'h17, 14'h0005, 8'h0B, 1'h1, 8'h03},
    {OP_SUB, 6'h27, 14'h000A, 8'hFF, 1'h1, 8'h00},
    {OP_MOVW, 6'h08, 14'h00A0, 8'hFF, 1'h0, 8'h00},
    {OP_INCF, 6'h19, 14'h00A0, 8'h00, 1'h1, 8'h04},
    {OP_RLF, 6'h04, 14'h0000, 8'hFE, 1'h1, 8'h05},
    {OP_SWAP, 6'h10, 14'h0000, 8'h42, 1'h0, 8'h00}};
  alu_working_register_datapath i_alu_working_register_datapath (
    .mclk_in, .rst_n_in, .insn_valid_in, .dec_in, .file_rdata_in, .fsr_in,
    .status_in, .file_raddr_out, .file_wr_out, .status_wr_out, .acc_out,
    .phase_out, .cycle_end_out, .insn_ready_out, .busy_out);
  alu_file_model i_alu_file_model (.mclk_in, .raddr_in(file_raddr_out),
    .wr_in(file_wr_out), .swr_in(status_wr_out), .rdata_out(file_rdata_in),
    .fsr_out(fsr_in), .status_out(status_in));
  initial begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Offer until taken, then wait for the write phase
  task automatic run_insn(input decode_s d);
    int n = 0;
    @(posedge mclk_in);
    dec_in <= d;
    insn_valid_in <= 1'h1;
    do @(negedge mclk_in);
    while (!(phase_out === PH_Q4 && insn_ready_out === 1'h1) && ++n < 60);
    check("take", 8'(n < 60), 8'h01);
    @(posedge mclk_in);
    insn_valid_in <= 1'h0;
    do @(negedge mclk_in);
    while (phase_out !== PH_Q4 && ++n < 90);
    check("exec", 8'(n < 90), 8'h01);
  endtask
  initial begin
    rst_n_in = 1'h0;
    insn_valid_in = 1'h0;
    dec_in = '0;
    acc_exp = 8'h00;
    repeat (20) @(posedge mclk_in);
    @(negedge mclk_in);
    check("acc", acc_out, 8'h00);
    check("phase", {4'h0, phase_out}, 8'h01);
    @(posedge mclk_in);
    rst_n_in <= 1'h1;
    $display("reset test done");
    foreach (rows[i]) begin
      run_insn(rows[i].d);
      if (!rows[i].d.dest_file) acc_exp = rows[i].res;
      check("acc", acc_out, acc_exp);
      check("fwr", 8'(file_wr_out.wr), 8'(rows[i].d.dest_file));
      if (rows[i].d.dest_file) check("fdat", file_wr_out.data, rows[i].res);
      if (rows[i].d.dest_file) check("fadr", {1'h0, file_wr_out.addr}, {1'h0, rows[i].d.insn[6:0]});
      check("swr", 8'(status_wr_out.wr), 8'(rows[i].sw));
      if (rows[i].sw) check("flags", status_wr_out.data, rows[i].sd);
      $display("row %0d done", i);
    end
    run_insn({OP_BRANCH, 6'h20, 14'h0000});
    check("rdy", 8'(insn_ready_out), 8'h00);
    check("acc", acc_out, acc_exp);
    $display("branch test done");
    @(posedge mclk_in);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    check("acc", acc_out, 8'h00);
    check("phase", {4'h0, phase_out}, 8'h01);
    check("rdy", 8'(insn_ready_out), 8'h01);
    @(posedge mclk_in);
    rst_n_in <= 1'h1;
    run_insn(rows[1].d);
    check("acc", acc_out, rows[1].res);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
